//--- logic/rspp_cfg.svh
// constants of the serial host port: offsets, reset values, timing
// Operation
// - commands arriving in the first 2.1 s after power-up are ignored.
// - bytes of a command inside that window are dropped, no response.
// - default link is 9600 baud, 8 data bits, odd parity, 1 stop, no flow.
// - from reset the port uses the binary protocol both ways.
// - in NMEA mode the link is 4800 baud, 8 data bits, no parity, 1 stop.
// - NMEA is output only; input is always parsed as binary packets.
// - NMEA output is printable ASCII with an identifier and comma fields.
// - command 0xBC selects the port protocol and the device applies it.
// - command 0x7A selects the NMEA sentences and their output rate.
// - with NMEA on and no selection made, ZDA goes out once a second.
// - settings live in battery-backed RAM, saved to flash by 0x8E-26.
// - saved port settings survive power loss and return at power-up.
// - serial lines carry plain non-inverted logic-level data.
`ifndef RSPP_CFG_SVH
`define RSPP_CFG_SVH
`define RSPP_CLK_HZ      125000000
`define RSPP_WIN_MS      2100
`define RSPP_SEC_MS      1000
`define RSPP_BAUD_BIN    9600
`define RSPP_BAUD_NMEA   4800
`define RSPP_ADDR_CFG    8'h00
`define RSPP_ADDR_STAT   8'h04
`define RSPP_ADDR_ERR    8'h08
`define RSPP_ADDR_CTRL   8'h0C
`define RSPP_CTRL_SAVE   0
`define RSPP_DLE         8'h10
`define RSPP_ETX         8'h03
`define RSPP_ID_PROTO    8'hBC
`define RSPP_ID_NMEA     8'h7A
`define RSPP_ID_SUPER    8'h8E
`define RSPP_SUB_SAVE    8'h26
`define RSPP_RST_RATE    8'h01
`define RSPP_RST_MASK    8'h01
`define RSPP_ZDA_LAST    5'd16
`endif

//--- logic/rspp_pkg.sv
// types of the serial host port
package rspp_pkg;
   typedef enum logic [0:0] {
      RSPP_PROTO_BIN  = 1'b0,
      RSPP_PROTO_NMEA = 1'b1
   } rspp_proto_type;
   typedef enum logic [4:0] {
      RSPP_U_IDLE  = 5'b00001,
      RSPP_U_START = 5'b00010,
      RSPP_U_DATA  = 5'b00100,
      RSPP_U_PAR   = 5'b01000,
      RSPP_U_STOP  = 5'b10000
   } rspp_ust_type;
   typedef enum logic [3:0] {
      RSPP_P_IDLE = 4'b0001,
      RSPP_P_ID   = 4'b0010,
      RSPP_P_BODY = 4'b0100,
      RSPP_P_DLE  = 4'b1000
   } rspp_pst_type;
   typedef struct packed {
      rspp_proto_type proto;
      logic [7:0]     rate;
      logic [7:0]     mask;
   } rspp_cfg_type;
   typedef struct packed {
      logic [7:0] data;
      logic       vld;
      logic       err;
   } rspp_rxb_type;
   typedef struct packed {
      rspp_ust_type st;
      logic [15:0]  cnt;
      logic [2:0]   idx;
      logic [7:0]   sh;
      logic         perr;
      rspp_rxb_type out;
   } rspp_rx_type;
   typedef struct packed {
      logic         rx_m;
      logic         rx_s;
      logic         boot;
      logic [31:0]  win_cnt;
      logic         win_done;
      logic [31:0]  sec_cnt;
      logic [7:0]   sec_n;
      logic         zda_due;
      rspp_cfg_type cfg;
      rspp_proto_type link;
      logic         nv_wr;
      rspp_pst_type pst;
      logic [7:0]   pid;
      logic [1:0]   pcnt;
      logic [7:0]   b0;
      logic [7:0]   b1;
      rspp_ust_type tst;
      logic [15:0]  tcnt;
      logic [2:0]   tidx;
      logic [7:0]   tsh;
      logic         tpar;
      logic [15:0]  tbit;
      logic         tline;
      logic         nact;
      logic [4:0]   nidx;
      logic [7:0]   ncs;
      logic [7:0]   rx_byte;
      logic         rx_vld;
      logic         rpt_rdy;
      logic [31:0]  rdata;
      logic [15:0]  err_cnt;
   } rspp_st_type;
endpackage

//--- logic/rspp_uart_rx.sv
// uart receiver: mid-bit sampling, optional odd parity, error flag
`timescale 1ns/1ps
`include "rspp_cfg.svh"
module rspp_uart_rx (
   input  wire logic                  ref_clk,
   input  wire logic                  srst,
   input  wire logic                  clk_en,
   input  wire logic                  rx_line,
   input  wire logic [15:0]           bit_cyc,
   input  wire logic                  par_en,
   output rspp_pkg::rspp_rxb_type     rxb
);
   rspp_pkg::rspp_rx_type s;
   rspp_pkg::rspp_rx_type n;

   always_comb begin
      n = s;
      n.out.vld = 1'b0;
      n.out.err = 1'b0;
      if (s.cnt != 16'h0000) begin
         n.cnt = s.cnt - 16'h0001;
      end
      case (s.st)
         rspp_pkg::RSPP_U_IDLE: begin
            if (!rx_line) begin
               n.st = rspp_pkg::RSPP_U_START;
               n.cnt = {1'b0, bit_cyc[15:1]};
            end
         end
         rspp_pkg::RSPP_U_START: begin
            if (s.cnt == 16'h0000) begin
               n.cnt = bit_cyc - 16'h0001;
               n.idx = 3'h0;
               n.perr = 1'b0;
               n.st = rx_line ? rspp_pkg::RSPP_U_IDLE
                              : rspp_pkg::RSPP_U_DATA;
            end
         end
         rspp_pkg::RSPP_U_DATA: begin
            if (s.cnt == 16'h0000) begin
               n.sh = {rx_line, s.sh[7:1]};
               n.cnt = bit_cyc - 16'h0001;
               n.idx = s.idx + 3'h1;
               if (s.idx == 3'h7) begin
                  n.st = par_en ? rspp_pkg::RSPP_U_PAR
                                : rspp_pkg::RSPP_U_STOP;
               end
            end
         end
         rspp_pkg::RSPP_U_PAR: begin
            if (s.cnt == 16'h0000) begin
               n.perr = ~(^{s.sh, rx_line});
               n.cnt = bit_cyc - 16'h0001;
               n.st = rspp_pkg::RSPP_U_STOP;
            end
         end
         rspp_pkg::RSPP_U_STOP: begin
            if (s.cnt == 16'h0000) begin
               n.out.data = s.sh;
               n.out.vld = 1'b1;
               n.out.err = s.perr | ~rx_line;
               n.st = rspp_pkg::RSPP_U_IDLE;
            end
         end
         default: begin
            n.st = rspp_pkg::RSPP_U_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s <= '0;
         s.st <= rspp_pkg::RSPP_U_IDLE;
      end else if (clk_en) begin
         s <= n;
      end
   end

   assign rxb = s.out;
endmodule

//--- logic/rspp_port.sv
// serial host port: binary command parser, uart transmit, nmea sentences
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "rspp_cfg.svh"
module rspp_port #(
   parameter int unsigned WIN_CYC =
      `RSPP_CLK_HZ / 1000 * `RSPP_WIN_MS,
   parameter int unsigned SEC_CYC =
      `RSPP_CLK_HZ / 1000 * `RSPP_SEC_MS,
   parameter int unsigned BIT_CYC_BIN =
      (`RSPP_CLK_HZ + `RSPP_BAUD_BIN - 1) / `RSPP_BAUD_BIN,
   parameter int unsigned BIT_CYC_NMEA =
      (`RSPP_CLK_HZ + `RSPP_BAUD_NMEA - 1) / `RSPP_BAUD_NMEA
) (
   input  wire logic                  ref_clk,
   input  wire logic                  srst,
   input  wire logic                  clk_en,
   input  wire logic                  rx_pin,
   output logic                       tx_pin,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [31:0]                reg_rdata,
   input  wire logic [7:0]            rpt_byte,
   input  wire logic                  rpt_valid,
   output logic                       rpt_ready,
   output logic [7:0]                 rx_byte,
   output logic                       rx_byte_vld,
   input  wire rspp_pkg::rspp_cfg_type nv_cfg,
   input  wire logic                  nv_ok,
   output rspp_pkg::rspp_cfg_type     nv_data,
   output logic                       nv_wr
);
   localparam logic [15:0] BIN_BIT  = BIT_CYC_BIN[15:0];
   localparam logic [15:0] NMEA_BIT = BIT_CYC_NMEA[15:0];
   rspp_pkg::rspp_st_type  s;
   rspp_pkg::rspp_st_type  n;
   rspp_pkg::rspp_rxb_type rxb;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] bit_of(
      input rspp_pkg::rspp_proto_type p);
      bit_of = (p == rspp_pkg::RSPP_PROTO_NMEA) ? NMEA_BIT
                                                : BIN_BIT;
   endfunction
   function automatic logic [7:0] hex_of(input logic [3:0] v);
      hex_of = {4'h0, v} + ((v < 4'hA) ? 8'h30 : 8'h37);
   endfunction
   // printable zda sentence with comma separated empty fields
   function automatic logic [7:0] zda_char(
      input logic [4:0] i,
      input logic [7:0] cs);
      case (i)
         5'd0:    zda_char = 8'h24;
         5'd1:    zda_char = 8'h47;
         5'd2:    zda_char = 8'h50;
         5'd3:    zda_char = 8'h5A;
         5'd4:    zda_char = 8'h44;
         5'd5:    zda_char = 8'h41;
         5'd12:   zda_char = 8'h2A;
         5'd13:   zda_char = hex_of(cs[7:4]);
         5'd14:   zda_char = hex_of(cs[3:0]);
         5'd15:   zda_char = 8'h0D;
         5'd16:   zda_char = 8'h0A;
         default: zda_char = 8'h2C;
      endcase
   endfunction
   // ----------------------------------------------------------------
   // receiver
   // ----------------------------------------------------------------
   rspp_uart_rx u_rx (
      .ref_clk (ref_clk),
      .srst    (srst),
      .clk_en  (clk_en),
      .rx_line (s.rx_s),
      .bit_cyc (bit_of(s.link)),
      .par_en  (s.link == rspp_pkg::RSPP_PROTO_BIN),
      .rxb     (rxb)
   );
   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic       take;
      logic       exec;
      logic [7:0] b;
      logic [7:0] ch;
      logic       keep;
      logic       due;
      take = 1'b0;
      exec = 1'b0;
      keep = 1'b0;
      due = 1'b0;
      b = rxb.data;
      ch = 8'h00;
      n = s;
      n.rx_m = rx_pin;
      n.rx_s = s.rx_m;
      n.nv_wr = 1'b0;
      n.rx_vld = 1'b0;
      n.rdata = 32'h0000_0000;
      // power-up restore from flash
      if (s.boot) begin
         n.boot = 1'b0;
         if (nv_ok) begin
            n.cfg = nv_cfg;
            n.link = nv_cfg.proto;
         end
      end
      // command window after power-up
      if (!s.win_done) begin
         if (s.win_cnt >= WIN_CYC - 1) begin
            n.win_done = 1'b1;
         end else begin
            n.win_cnt = s.win_cnt + 32'h0000_0001;
         end
      end
      // received bytes: drop errors and anything inside the window
      if (rxb.vld) begin
         if (rxb.err) begin
            n.err_cnt = s.err_cnt + 16'h0001;
         end else if (s.win_done) begin
            take = 1'b1;
            n.rx_byte = b;
            n.rx_vld = 1'b1;
         end
      end
      // binary packet parser, the only input protocol
      if (take) begin
         case (s.pst)
            rspp_pkg::RSPP_P_IDLE: begin
               if (b == `RSPP_DLE) begin
                  n.pst = rspp_pkg::RSPP_P_ID;
               end
            end
            rspp_pkg::RSPP_P_ID: begin
               if (b == `RSPP_DLE || b == `RSPP_ETX) begin
                  n.pst = rspp_pkg::RSPP_P_IDLE;
               end else begin
                  n.pid = b;
                  n.pcnt = 2'd0;
                  n.pst = rspp_pkg::RSPP_P_BODY;
               end
            end
            rspp_pkg::RSPP_P_BODY: begin
               if (b == `RSPP_DLE) begin
                  n.pst = rspp_pkg::RSPP_P_DLE;
               end else begin
                  keep = 1'b1;
               end
            end
            rspp_pkg::RSPP_P_DLE: begin
               if (b == `RSPP_ETX) begin
                  exec = 1'b1;
                  n.pst = rspp_pkg::RSPP_P_IDLE;
               end else if (b == `RSPP_DLE) begin
                  keep = 1'b1;
                  n.pst = rspp_pkg::RSPP_P_BODY;
               end else begin
                  n.pid = b;
                  n.pcnt = 2'd0;
                  n.pst = rspp_pkg::RSPP_P_BODY;
               end
            end
            default: begin
               n.pst = rspp_pkg::RSPP_P_IDLE;
            end
         endcase
      end
      if (keep && s.pcnt != 2'd2) begin
         n.pcnt = s.pcnt + 2'd1;
         n.b0 = (s.pcnt == 2'd0) ? b : s.b0;
         n.b1 = (s.pcnt == 2'd1) ? b : s.b1;
      end
      // command execution
      if (exec) begin
         if (s.pid == `RSPP_ID_PROTO && s.pcnt != 2'd0) begin
            n.cfg.proto = rspp_pkg::rspp_proto_type'(s.b0[0]);
         end else if (s.pid == `RSPP_ID_NMEA && s.pcnt == 2'd2) begin
            n.cfg.rate = s.b0;
            n.cfg.mask = s.b1;
         end else if (s.pid == `RSPP_ID_SUPER && s.pcnt != 2'd0
                      && s.b0 == `RSPP_SUB_SAVE) begin
            n.nv_wr = 1'b1;
         end
      end
      // register port
      if (reg_wr) begin
         if (reg_addr == `RSPP_ADDR_CFG) begin
            n.cfg = reg_wdata[16:0];
         end else if (reg_addr == `RSPP_ADDR_CTRL) begin
            n.nv_wr = n.nv_wr | reg_wdata[`RSPP_CTRL_SAVE];
         end
      end
      if (reg_rd) begin
         if (reg_addr == `RSPP_ADDR_CFG) begin
            n.rdata = {15'h0000, s.cfg};
         end else if (reg_addr == `RSPP_ADDR_STAT) begin
            n.rdata = {28'h000_0000, s.nact, s.tst != rspp_pkg::RSPP_U_IDLE,
                       s.link, s.win_done};
         end else if (reg_addr == `RSPP_ADDR_ERR) begin
            n.rdata = {16'h0000, s.err_cnt};
         end
      end
      // second tick and sentence scheduling
      if (s.sec_cnt >= SEC_CYC - 1) begin
         n.sec_cnt = 32'h0000_0000;
         n.sec_n = s.sec_n + 8'h01;
         if (s.sec_n + 8'h01 >= s.cfg.rate) begin
            n.sec_n = 8'h00;
            if (s.link == rspp_pkg::RSPP_PROTO_NMEA
                && (s.cfg.mask == 8'h00 || s.cfg.mask[0])) begin
               due = 1'b1;
            end
         end
      end else begin
         n.sec_cnt = s.sec_cnt + 32'h0000_0001;
      end
      // transmitter
      case (s.tst)
         rspp_pkg::RSPP_U_IDLE: begin
            n.tline = 1'b1;
            n.link = s.cfg.proto;
            if (s.link != s.cfg.proto) begin
               n.nact = 1'b0;
            end else if (s.nact) begin
               ch = zda_char(s.nidx, s.ncs);
               if (s.nidx != 5'd0 && s.nidx < 5'd12) begin
                  n.ncs = s.ncs ^ ch;
               end
               n.nidx = s.nidx + 5'd1;
               if (s.nidx == `RSPP_ZDA_LAST) begin
                  n.nact = 1'b0;
               end
               n.tst = rspp_pkg::RSPP_U_START;
            end else if (s.zda_due
                         && s.link == rspp_pkg::RSPP_PROTO_NMEA) begin
               n.zda_due = 1'b0;
               n.nact = 1'b1;
               n.nidx = 5'd0;
               n.ncs = 8'h00;
            end else if (rpt_valid && s.rpt_rdy) begin
               ch = rpt_byte;
               n.tst = rspp_pkg::RSPP_U_START;
            end
            if (n.tst == rspp_pkg::RSPP_U_START) begin
               n.tsh = ch;
               n.tidx = 3'h0;
               n.tbit = bit_of(s.link);
               n.tcnt = bit_of(s.link) - 16'h0001;
               n.tpar = s.link == rspp_pkg::RSPP_PROTO_BIN;
               n.tline = 1'b0;
            end
         end
         rspp_pkg::RSPP_U_START: begin
            if (s.tcnt == 16'h0000) begin
               n.tcnt = s.tbit - 16'h0001;
               n.tline = s.tsh[0];
               n.tst = rspp_pkg::RSPP_U_DATA;
            end
         end
         rspp_pkg::RSPP_U_DATA: begin
            if (s.tcnt == 16'h0000) begin
               n.tcnt = s.tbit - 16'h0001;
               if (s.tidx == 3'h7) begin
                  if (s.tpar) begin
                     n.tline = ~(^s.tsh);
                     n.tst = rspp_pkg::RSPP_U_PAR;
                  end else begin
                     n.tline = 1'b1;
                     n.tst = rspp_pkg::RSPP_U_STOP;
                  end
               end else begin
                  n.tidx = s.tidx + 3'h1;
                  n.tline = s.tsh[s.tidx + 3'h1];
               end
            end
         end
         rspp_pkg::RSPP_U_PAR: begin
            if (s.tcnt == 16'h0000) begin
               n.tcnt = s.tbit - 16'h0001;
               n.tline = 1'b1;
               n.tst = rspp_pkg::RSPP_U_STOP;
            end
         end
         rspp_pkg::RSPP_U_STOP: begin
            if (s.tcnt == 16'h0000) begin
               n.tst = rspp_pkg::RSPP_U_IDLE;
            end
         end
         default: begin
            n.tst = rspp_pkg::RSPP_U_IDLE;
         end
      endcase
      if (s.tst != rspp_pkg::RSPP_U_IDLE && s.tcnt != 16'h0000) begin
         n.tcnt = s.tcnt - 16'h0001;
      end
      if (due) begin
         n.zda_due = 1'b1;
      end
      // report port is open only for an idle binary link
      n.rpt_rdy = n.tst == rspp_pkg::RSPP_U_IDLE && !n.nact
                  && n.link == rspp_pkg::RSPP_PROTO_BIN
                  && n.cfg.proto == rspp_pkg::RSPP_PROTO_BIN
                  && !(rpt_valid && s.rpt_rdy);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s <= '0;
         s.rx_m <= 1'b1;
         s.rx_s <= 1'b1;
         s.boot <= 1'b1;
         s.cfg.rate <= `RSPP_RST_RATE;
         s.cfg.mask <= `RSPP_RST_MASK;
         s.pst <= rspp_pkg::RSPP_P_IDLE;
         s.tst <= rspp_pkg::RSPP_U_IDLE;
         s.tline <= 1'b1;
      end else if (clk_en) begin
         s <= n;
      end
   end

   assign tx_pin = s.tline;
   assign reg_rdata = s.rdata;
   assign rpt_ready = s.rpt_rdy;
   assign rx_byte = s.rx_byte;
   assign rx_byte_vld = s.rx_vld;
   assign nv_data = s.cfg;
   assign nv_wr = s.nv_wr;
endmodule

//--- sim/rspp_port_assertions.sv
// concurrent checks of the serial host port, bound to its top module
`timescale 1ns/1ps
module rspp_port_assertions #(
   parameter int unsigned WIN_CYC     = 2000,
   parameter int unsigned BIT_CYC_BIN = 16
) (
   input wire logic                   ref_clk,
   input wire logic                   srst,
   input wire logic                   tx_pin,
   input wire logic [7:0]             reg_addr,
   input wire logic [31:0]            reg_wdata,
   input wire logic                   reg_wr,
   input wire logic                   rpt_valid,
   input wire logic                   rpt_ready,
   input wire logic                   rx_byte_vld,
   input wire rspp_pkg::rspp_cfg_type nv_cfg,
   input wire logic                   nv_ok,
   input wire rspp_pkg::rspp_cfg_type nv_data,
   input wire logic                   nv_wr
);
   logic [31:0] win_q;
   logic [31:0] low_q;
   logic        busy_q;
   // window and frame counters
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         win_q  <= '0;
         low_q  <= '0;
         busy_q <= 1'b0;
      end else begin
         if (win_q < WIN_CYC) win_q <= win_q + 1;
         if (rpt_valid && rpt_ready) busy_q <= 1'b1;
         else if (rpt_ready) busy_q <= 1'b0;
         low_q <= (rpt_valid && rpt_ready) ? '0 : low_q + 1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   win_quiet_a: assert property (
      win_q + 4 < WIN_CYC |-> !rx_byte_vld) else $error("rx byte in window");
   win_nosave_a: assert property (
      win_q + 4 < WIN_CYC && !$past(reg_wr) |-> !nv_wr)
      else $error("command acted on in window");
   tx_start_a: assert property (
      rpt_valid && rpt_ready |=> !tx_pin && !rpt_ready)
      else $error("no start bit after take");
   start_hold_a: assert property (
      rpt_valid && rpt_ready |=> (!tx_pin) [*8]) else $error("start bit short");
   frame_len_a: assert property (
      busy_q && rpt_ready |-> low_q >= 10 * BIT_CYC_BIN)
      else $error("frame cut short");
   idle_high_a: assert property (
      rpt_ready |-> tx_pin) else $error("tx line low while idle");
   save_pulse_a: assert property (
      nv_wr |=> !nv_wr) else $error("save pulse too long");
   ctrl_save_a: assert property (
      reg_wr && reg_addr == 8'h0C && reg_wdata[0] |=> nv_wr)
      else $error("save request lost");
   boot_dflt_a: assert property (
      $fell(srst) && !nv_ok |-> ##2 nv_data == 17'h0_0101)
      else $error("wrong default settings");
   boot_rest_a: assert property (
      $fell(srst) && nv_ok |-> ##2 nv_data == nv_cfg)
      else $error("saved settings not restored");
   cover property (rpt_valid && rpt_ready);
   cover property (nv_wr);
   cover property ($fell(srst) && nv_ok);
endmodule
bind rspp_port rspp_port_assertions #(
   .WIN_CYC(WIN_CYC), .BIT_CYC_BIN(BIT_CYC_BIN)
) i_rspp_port_assertions (
   .ref_clk(ref_clk), .srst(srst), .tx_pin(tx_pin), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .rpt_valid(rpt_valid),
   .rpt_ready(rpt_ready), .rx_byte_vld(rx_byte_vld), .nv_cfg(nv_cfg),
   .nv_ok(nv_ok), .nv_data(nv_data), .nv_wr(nv_wr)
);

//--- sim/rspp_host.sv
// host uart model on the far side of the serial port
`timescale 1ns/1ps
module rspp_host (
   input  wire logic        ref_clk,
   input  wire logic        tx_pin,
   input  wire logic [15:0] bit_cyc,
   input  wire logic        par_en,
   output logic             rx_pin,
   output logic             got,
   output logic [7:0]       got_byte,
   output logic             got_bad
);
   logic [7:0] d;
   logic       bad;
   initial begin
      rx_pin   = 1'b1; // idle high, not inverted
      got      = 1'b0;
      got_byte = 8'h00;
      got_bad  = 1'b0;
   end
   task automatic bit_out(input logic v);
      rx_pin <= v;
      repeat (bit_cyc) @(posedge ref_clk);
   endtask
   // start, lsb first, odd parity if enabled, stop
   task automatic send_byte(input logic [7:0] b, input logic flip);
      @(posedge ref_clk);
      bit_out(1'b0);
      for (int i = 0; i < 8; i++) bit_out(b[i]);
      if (par_en) bit_out(~^b ^ flip);
      bit_out(1'b1);
   endtask
   // mid-bit receiver of the device's transmit line
   initial forever begin
      @(negedge tx_pin);
      repeat (bit_cyc / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_cyc) @(posedge ref_clk);
         d[i] = tx_pin;
      end
      bad = 1'b0;
      if (par_en) begin
         repeat (bit_cyc) @(posedge ref_clk);
         bad = (^{d, tx_pin}) !== 1'b1;
      end
      repeat (bit_cyc) @(posedge ref_clk);
      bad = bad | (tx_pin !== 1'b1);
      got_byte <= d;
      got_bad  <= bad;
      got      <= 1'b1;
      @(posedge ref_clk);
      got      <= 1'b0;
   end
endmodule

//--- sim/rspp_port_test.sv
// self-checking bench of the serial host port
`timescale 1ns/1ps
module rspp_port_test;
   logic                   ref_clk;
   logic                   srst;
   logic                   rx_pin;
   logic                   tx_pin;
   logic [7:0]             reg_addr;
   logic [31:0]            reg_wdata;
   logic                   reg_wr;
   logic                   reg_rd;
   logic [31:0]            reg_rdata;
   logic [7:0]             rpt_byte;
   logic                   rpt_valid;
   logic                   rpt_ready;
   logic                   rx_byte_vld;
   rspp_pkg::rspp_cfg_type nv_cfg;
   logic                   nv_ok;
   rspp_pkg::rspp_cfg_type nv_data;
   logic                   nv_wr;
   logic [15:0]            h_bit;
   logic                   h_par;
   logic                   got;
   logic [7:0]             got_byte;
   logic                   got_bad;
   logic                   rd_d1 = 1'b0;
   logic [31:0]            rd_q[$];
   logic [7:0]             tx_q[$];
   logic [15:0]            seed;
   int                     fail_count;
   int                     total_checks;
   int                     rx_n;
   int                     nvw_n;
   string                  zda;
   rspp_port #(.WIN_CYC(2000), .SEC_CYC(3000), .BIT_CYC_BIN(16),
      .BIT_CYC_NMEA(32)) i_rspp_port (.ref_clk(ref_clk), .srst(srst),
      .clk_en(1'b1), .rx_pin(rx_pin), .tx_pin(tx_pin), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rpt_byte(rpt_byte), .rpt_valid(rpt_valid),
      .rpt_ready(rpt_ready), .rx_byte(), .rx_byte_vld(rx_byte_vld),
      .nv_cfg(nv_cfg), .nv_ok(nv_ok), .nv_data(nv_data), .nv_wr(nv_wr));
   rspp_host i_rspp_host (.ref_clk(ref_clk), .tx_pin(tx_pin),
      .bit_cyc(h_bit), .par_en(h_par), .rx_pin(rx_pin), .got(got),
      .got_byte(got_byte), .got_bad(got_bad));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      rd_q.push_back(e);
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic pkt(input logic [7:0] id, d0, d1, input int n);
      i_rspp_host.send_byte(8'h10, 1'b0);
      i_rspp_host.send_byte(id, 1'b0);
      if (n > 0) i_rspp_host.send_byte(d0, 1'b0);
      if (n > 1) i_rspp_host.send_byte(d1, 1'b0);
      i_rspp_host.send_byte(8'h10, 1'b0);
      i_rspp_host.send_byte(8'h03, 1'b0);
   endtask
   task automatic rpt(input logic [7:0] b);
      int n;
      n = 0;
      @(posedge ref_clk);
      rpt_byte  <= b;
      rpt_valid <= 1'b1;
      tx_q.push_back(b);
      do begin
         @(negedge ref_clk);
         n++;
      end while (rpt_ready !== 1'b1 && n < 400);
      chk(n < 400, "report not taken");
      @(posedge ref_clk);
      rpt_valid <= 1'b0;
   endtask
   task automatic drain(input int lim);
      int n;
      n = 0;
      while (tx_q.size() > 0 && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
      chk(n < lim, "tx bytes missing");
   endtask
   // ------------------------------------------------------------
   // watchers
   // ------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (rd_d1 === 1'b1) chk(reg_rdata === rd_q.pop_front(), "read");
      rd_d1 <= reg_rd;
      if (rx_byte_vld === 1'b1) rx_n++;
      if (nv_wr === 1'b1) nvw_n++;
   end
   always @(posedge got) chk(got_bad === 1'b0 && tx_q.size() > 0 &&
      got_byte === tx_q.pop_front(), "tx byte");
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (80000) @(posedge ref_clk);
      fail_count++;
      tally_and_finish();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      srst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rpt_byte = 8'h00;
      rpt_valid = 1'b0;
      nv_cfg = 17'h0_0000;
      nv_ok = 1'b0;
      h_bit = 16'h0010;
      h_par = 1'b1;
      seed = 16'h9931;
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      rd(8'h00, 32'h0000_0101);
      rd(8'h04, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      pkt(8'hBC, 8'h01, 8'h00, 1);
      rd(8'h00, 32'h0000_0101);
      repeat (1200) @(posedge ref_clk);
      rd(8'h04, 32'h0000_0001);
      i_rspp_host.send_byte(8'h55, 1'b1);
      rd(8'h08, 32'h0000_0001);
      chk(rx_n == 0, "dropped bytes passed on");
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         rpt(seed[7:0]);
      end
      drain(400);
      pkt(8'h7A, 8'h02, 8'h00, 2);
      rd(8'h00, 32'h0000_0200);
      pkt(8'h8E, 8'h26, 8'h00, 1);
      chk(nvw_n == 1 && nv_data === 17'h0_0200, "save");
      wr(8'h0C, 32'h0000_0001);
      repeat (2) @(posedge ref_clk);
      chk(nvw_n == 2, "register save");
      pkt(8'hBC, 8'h01, 8'h00, 1);
      h_bit <= 16'h0020;
      h_par <= 1'b0;
      zda = "$GPZDA,,,,,,*48\r\n";
      foreach (zda[i]) tx_q.push_back(zda[i]);
      rd(8'h00, 32'h0001_0200);
      drain(20000);
      nv_cfg <= 17'h0_0200;
      nv_ok <= 1'b1;
      srst <= 1'b1;
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      rd(8'h00, 32'h0000_0200);
      repeat (2) @(posedge ref_clk);
      tally_and_finish();
   end
endmodule
